// ### include/aelf_pkg.sv
//=====================================================================
// shared constants of the amplifier event latch and flag block
//=====================================================================
package aelf_pkg;

   // control port target address, value is arbitrary
   localparam logic [6:0]  I2C_DEV_ADDR      = 7'h38;

   // register map, 16-bit register addresses
   localparam logic [15:0] OFS_SUPPLY_STATE  = 16'h2008;
   localparam logic [15:0] OFS_BROWN_STATE   = 16'h2009;
   localparam logic [15:0] OFS_THERM_FLAGS   = 16'h200b;
   localparam logic [15:0] OFS_SUPPLY_CLR    = 16'h2010;
   localparam logic [15:0] OFS_BROWN_CLR     = 16'h2011;
   localparam logic [15:0] OFS_THERM_CLR     = 16'h2012;
   localparam logic [15:0] OFS_THERM_MASK    = 16'h2013;
   localparam logic [15:0] OFS_IRQ_CTRL      = 16'h2014;

   // reset values
   localparam logic [7:0]  RST_REG           = 8'h00;
   localparam logic        RST_IRQ_EN        = 1'b0;

   // supply and power state bits
   localparam int B_PWR_ON    = 5;
   localparam int B_PWR_OFF   = 4;
   localparam int B_HIGH_UV   = 3;
   localparam int B_BATT_UV   = 2;
   localparam int B_HR_START  = 1;
   localparam int B_HR_STOP   = 0;
   // brownout state bits
   localparam int B_BO_LVL0   = 3;
   localparam int B_BO_LVLCH  = 2;
   localparam int B_BO_START  = 1;
   localparam int B_BO_STOP   = 0;
   // thermal and fault flag bits
   localparam int B_OT_START  = 7;
   localparam int B_OT_STOP   = 6;
   localparam int B_HW_START  = 5;
   localparam int B_HW_STOP   = 4;
   localparam int B_FB_START  = 3;
   localparam int B_FB_STOP   = 2;
   localparam int B_LOAD_FAIL = 1;
   localparam int B_SPK_OVC   = 0;

   // control port byte engine, gray along the usual path except ACK to TX
   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_DEV  = 3'b001,
      I2C_ACK  = 3'b011,
      I2C_RX   = 3'b010,
      I2C_TX   = 3'b110,
      I2C_RACK = 3'b111
   } aelf_i2c_st_t;

endpackage : aelf_pkg

// ### verilog/aelf_edge_latch.sv
`timescale 1ns/1ns
`default_nettype none
//=====================================================================
// rising edge detect with sticky latch, set wins over clear
//=====================================================================
module aelf_edge_latch
   import aelf_pkg::*;
#(
   parameter int W = 8
)
(
   input  wire logic         clock_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] raw_i,
   input  wire logic [W-1:0] clr_i,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] latch_o
);

   logic [W-1:0] raw_q;

   // a level already high at reset release counts as an edge
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         raw_q <= '0;
      else
         raw_q <= raw_i;
   end

   assign rise_o = raw_i & ~raw_q;

   // an edge in the clearing cycle is kept
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         latch_o <= '0;
      else
         latch_o <= rise_o | (latch_o & ~clr_i);
   end

endmodule : aelf_edge_latch
`default_nettype wire

// ### verilog/aelf_irq_gen.sv
`timescale 1ns/1ns
`default_nettype none
//=====================================================================
// interrupt pulse on any flag rising edge
//=====================================================================
module aelf_irq_gen
   import aelf_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic [7:0] flags_i,
   input  wire logic       irq_en_i,
   output logic            irq_o
);

   logic [7:0] flags_q;

   // previous flags, so only new flags fire
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         flags_q <= RST_REG;
      else
         flags_q <= flags_i;
   end

   // one pulse per rising edge; held flags stay quiet
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         irq_o <= 1'b0;
      else
         irq_o <= irq_en_i && ((flags_i & ~flags_q) != 8'h00);
   end

endmodule : aelf_irq_gen
`default_nettype wire

// ### verilog/aelf_event_latch_flag.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - power-on complete latch, bit 5, sticky
// - power-off complete latch, bit 4, sticky
// - high rail undervolt latch, bit 3
// - battery rail undervolt latch, bit 2
// - headroom track start latch, bit 1
// - headroom track stop latch, bit 0
// - brownout level zero latch, bit 3
// - brownout level change latch, bit 2
// - brownout start latch bit 1, own clear
// - brownout stop latch bit 0, own clear
// - overtemp start flag bit 7, own mask
// - overtemp stop flag bit 6, mask and edge
// - heat warning start flag, bit 5
// - heat warning stop flag, bit 4
// - foldback start flag, bit 3
// - foldback stop flag, bit 2
// - memory load failure flag, bit 1
// - speaker overcurrent flag, bit 0
// - flag rising edge interrupts when enabled
module aelf_event_latch_flag
   import aelf_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic srst_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   input  wire logic power_on_complete_raw_i,
   input  wire logic power_off_complete_raw_i,
   input  wire logic high_rail_undervolt_raw_i,
   input  wire logic battery_rail_undervolt_raw_i,
   input  wire logic headroom_track_start_raw_i,
   input  wire logic headroom_track_stop_raw_i,
   input  wire logic brownout_level_zero_raw_i,
   input  wire logic brownout_level_change_raw_i,
   input  wire logic brownout_start_raw_i,
   input  wire logic brownout_stop_raw_i,
   input  wire logic overtemp_shutdown_start_raw_i,
   input  wire logic overtemp_shutdown_stop_raw_i,
   input  wire logic heat_warning_one_start_raw_i,
   input  wire logic heat_warning_one_stop_raw_i,
   input  wire logic heat_foldback_start_raw_i,
   input  wire logic heat_foldback_stop_raw_i,
   input  wire logic load_fail_raw_i,
   input  wire logic speaker_overcurrent_raw_i,
   output logic      irq_o
);

   //==================================================================
   // control port pin sampling
   //==================================================================
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // pins are synchronous; one stage of history finds edges
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   assign scl_rise  = scl_i & ~scl_q;
   assign scl_fall  = ~scl_i & scl_q;
   assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
   assign bus_stop  = scl_i & scl_q & ~sda_q & sda_i;

   //==================================================================
   // control port byte engine
   //==================================================================
   aelf_i2c_st_t st_q;
   logic [3:0]   bit_q;
   logic [7:0]   sh_q;
   logic [1:0]   byte_q;
   logic         read_q;
   logic [15:0]  addr_q;
   logic         oe_q;
   logic         wr_stb_q;
   logic [15:0]  wr_addr_q;
   logic [7:0]   wr_data_q;
   logic [7:0]   rd_now;

   // open drain: the line is only ever pulled low
   assign sda_o    = 1'b0;
   assign sda_oe_o = oe_q;

   // first two bytes after the address pick the register, then
   // data bytes follow with auto increment in both directions
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         st_q      <= I2C_IDLE;
         bit_q     <= 4'h0;
         sh_q      <= RST_REG;
         byte_q    <= 2'd0;
         read_q    <= 1'b0;
         addr_q    <= 16'h0000;
         oe_q      <= 1'b0;
         wr_stb_q  <= 1'b0;
         wr_addr_q <= 16'h0000;
         wr_data_q <= RST_REG;
      end
      else
      begin
         wr_stb_q <= 1'b0;
         if (bus_start)
         begin
            st_q   <= I2C_DEV;
            bit_q  <= 4'h0;
            byte_q <= 2'd0;
            oe_q   <= 1'b0;
         end
         else if (bus_stop)
         begin
            st_q <= I2C_IDLE;
            oe_q <= 1'b0;
         end
         else
         begin
            case (st_q)
               I2C_DEV, I2C_RX:
               begin
                  if (scl_rise)
                  begin
                     sh_q  <= {sh_q[6:0], sda_i};
                     bit_q <= bit_q + 4'h1;
                  end
                  else if (scl_fall && bit_q == 4'h8)
                  begin
                     if (st_q == I2C_DEV)
                     begin
                        // a foreign address leaves the bus alone
                        if (sh_q[7:1] == I2C_DEV_ADDR)
                        begin
                           read_q <= sh_q[0];
                           oe_q   <= 1'b1;
                           st_q   <= I2C_ACK;
                        end
                        else
                           st_q <= I2C_IDLE;
                     end
                     else
                     begin
                        oe_q <= 1'b1;
                        st_q <= I2C_ACK;
                        if (byte_q == 2'd0)
                           addr_q[15:8] <= sh_q;
                        else if (byte_q == 2'd1)
                           addr_q[7:0] <= sh_q;
                        else
                        begin
                           wr_stb_q  <= 1'b1;
                           wr_addr_q <= addr_q;
                           wr_data_q <= sh_q;
                           addr_q    <= addr_q + 16'h0001;
                        end
                        if (byte_q != 2'd2)
                           byte_q <= byte_q + 2'd1;
                     end
                  end
               end
               I2C_ACK:
               begin
                  if (scl_fall)
                  begin
                     bit_q <= 4'h0;
                     if (read_q)
                     begin
                        st_q   <= I2C_TX;
                        sh_q   <= rd_now;
                        oe_q   <= ~rd_now[7];
                        addr_q <= addr_q + 16'h0001;
                     end
                     else
                     begin
                        st_q <= I2C_RX;
                        oe_q <= 1'b0;
                     end
                  end
               end
               I2C_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bit_q == 4'h7)
                     begin
                        st_q <= I2C_RACK;
                        oe_q <= 1'b0;
                     end
                     else
                     begin
                        sh_q  <= {sh_q[6:0], 1'b0};
                        oe_q  <= ~sh_q[6];
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               I2C_RACK:
               begin
                  // sda_q holds the level seen while the clock was high
                  if (scl_fall)
                  begin
                     bit_q <= 4'h0;
                     if (!sda_q)
                     begin
                        st_q   <= I2C_TX;
                        sh_q   <= rd_now;
                        oe_q   <= ~rd_now[7];
                        addr_q <= addr_q + 16'h0001;
                     end
                     else
                        st_q <= I2C_IDLE;
                  end
               end
               default:
               begin
                  oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   //==================================================================
   // events, latches and flags
   //==================================================================
   logic [5:0] sup_raw;
   logic [3:0] bo_raw;
   logic [7:0] th_raw;
   logic [5:0] sup_clr;
   logic [3:0] bo_clr;
   logic [7:0] th_clr;
   logic [5:0] sup_rise;
   logic [3:0] bo_rise;
   logic [7:0] th_rise;
   logic [5:0] sup_state;
   logic [3:0] bo_state;
   logic [7:0] th_sticky;
   logic [7:0] th_flags;
   logic [7:0] mask_q;
   logic       irq_en_q;

   // supply and power events, never masked
   assign sup_raw[B_PWR_ON]  = power_on_complete_raw_i;
   assign sup_raw[B_PWR_OFF] = power_off_complete_raw_i;
   assign sup_raw[B_HIGH_UV] = high_rail_undervolt_raw_i;
   assign sup_raw[B_BATT_UV] = battery_rail_undervolt_raw_i;
   assign sup_raw[B_HR_START] = headroom_track_start_raw_i;
   assign sup_raw[B_HR_STOP] = headroom_track_stop_raw_i;
   // brownout events; each start and stop has its own clear bit
   assign bo_raw[B_BO_LVL0]  = brownout_level_zero_raw_i;
   assign bo_raw[B_BO_LVLCH] = brownout_level_change_raw_i;
   assign bo_raw[B_BO_START] = brownout_start_raw_i;
   assign bo_raw[B_BO_STOP]  = brownout_stop_raw_i;
   // thermal and fault events, gated by their own mask bits
   assign th_raw[B_OT_START] = overtemp_shutdown_start_raw_i;
   assign th_raw[B_OT_STOP]  = overtemp_shutdown_stop_raw_i;
   assign th_raw[B_HW_START] = heat_warning_one_start_raw_i;
   assign th_raw[B_HW_STOP]  = heat_warning_one_stop_raw_i;
   assign th_raw[B_FB_START] = heat_foldback_start_raw_i;
   assign th_raw[B_FB_STOP]  = heat_foldback_stop_raw_i;
   assign th_raw[B_LOAD_FAIL] = load_fail_raw_i;
   assign th_raw[B_SPK_OVC]  = speaker_overcurrent_raw_i;

   // clear registers act only on written ones, then read back zero
   always_comb
   begin
      sup_clr = 6'h00;
      bo_clr  = 4'h0;
      th_clr  = 8'h00;
      if (wr_stb_q && wr_addr_q == OFS_SUPPLY_CLR)
         sup_clr = wr_data_q[5:0];
      else if (wr_stb_q && wr_addr_q == OFS_BROWN_CLR)
         bo_clr = wr_data_q[3:0];
      else if (wr_stb_q && wr_addr_q == OFS_THERM_CLR)
         th_clr = wr_data_q;
   end

   aelf_edge_latch #(.W(6)) u_supply (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .raw_i   (sup_raw),
      .clr_i   (sup_clr),
      .rise_o  (sup_rise),
      .latch_o (sup_state)
   );

   aelf_edge_latch #(.W(4)) u_brown (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .raw_i   (bo_raw),
      .clr_i   (bo_clr),
      .rise_o  (bo_rise),
      .latch_o (bo_state)
   );

   aelf_edge_latch #(.W(8)) u_therm (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .raw_i   (th_raw),
      .clr_i   (th_clr),
      .rise_o  (th_rise),
      .latch_o (th_sticky)
   );

   // the edge is remembered while masked and shows once unmasked
   assign th_flags = th_sticky & mask_q;

   // mask and interrupt enable, written by the host
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         mask_q   <= RST_REG;
         irq_en_q <= RST_IRQ_EN;
      end
      else if (wr_stb_q && wr_addr_q == OFS_THERM_MASK)
         mask_q <= wr_data_q;
      else if (wr_stb_q && wr_addr_q == OFS_IRQ_CTRL)
         irq_en_q <= wr_data_q[0];
   end

   // only flags reach the interrupt; state bits never do
   aelf_irq_gen u_irq (
      .clock_i  (clock_i),
      .srst_i   (srst_i),
      .flags_i  (th_flags),
      .irq_en_i (irq_en_q),
      .irq_o    (irq_o)
   );

   // read mux; unmapped and clear registers read zero
   always_comb
   begin
      rd_now = RST_REG;
      if (addr_q == OFS_SUPPLY_STATE)
         rd_now = {2'b00, sup_state};
      else if (addr_q == OFS_BROWN_STATE)
         rd_now = {4'h0, bo_state};
      else if (addr_q == OFS_THERM_FLAGS)
         rd_now = th_flags;
      else if (addr_q == OFS_THERM_MASK)
         rd_now = mask_q;
      else if (addr_q == OFS_IRQ_CTRL)
         rd_now = {7'h00, irq_en_q};
   end

   //==================================================================
   // checks
   //==================================================================
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   sequence s_flag_edge;
      (th_flags & ~$past(th_flags)) != 8'h00;
   endsequence

   sequence s_irq_seen;
      ##1 irq_o;
   endsequence

   chk_supply_set: assert property (
      (sup_rise != 6'h00) |=> ((sup_state & $past(sup_rise))
                                == $past(sup_rise)))
      else $error("supply event edge not latched");

   chk_supply_hold: assert property (
      1'b1 |=> ((sup_state & $past(sup_state & ~sup_clr))
                == $past(sup_state & ~sup_clr)))
      else $error("supply latch lost without clear");

   chk_brown_latch: assert property (
      (bo_rise != 4'h0) |=> ((bo_state & $past(bo_rise))
                             == $past(bo_rise)))
      else $error("brownout edge not latched");

   chk_brown_clear: assert property (
      (bo_clr != 4'h0) |=> ((bo_state & $past(bo_clr & ~bo_rise))
                            == 4'h0))
      else $error("brownout clear had no effect");

   chk_supply_clear: assert property (
      (sup_clr != 6'h00) |=> ((sup_state & $past(sup_clr & ~sup_rise))
                              == 6'h00))
      else $error("supply clear had no effect");

   // mask may change in the same cycle, so judge against the new mask
   chk_flag_masked: assert property (
      (th_rise != 8'h00) |=> ((th_flags & $past(th_rise) & mask_q)
                              == ($past(th_rise) & mask_q)))
      else $error("unmasked flag not raised");

   chk_flag_gate: assert property (
      ((th_flags & ~mask_q) == 8'h00) and
      ($stable(mask_q) && th_clr == 8'h00 |=>
         ((th_flags & $past(th_flags) & mask_q)
          == ($past(th_flags) & mask_q))))
      else $error("flag shown while masked or dropped");

   chk_irq_edge: assert property (
      (s_flag_edge ##0 irq_en_q) |-> s_irq_seen)
      else $error("flag edge gave no interrupt");

   chk_irq_quiet: assert property (
      (th_flags == $past(th_flags)) |=> !irq_o)
      else $error("interrupt without a new flag");

   chk_ack_drive: assert property (
      (st_q == I2C_ACK) |-> sda_oe_o)
      else $error("acknowledge not driven");

endmodule : aelf_event_latch_flag
`default_nettype wire

// ### sim/aelf_i2c_host.sv
`timescale 1ns/1ns
`default_nettype none
//=====================================================================
// control port host model, pulls sda low while sda_oe_o is high
//=====================================================================
module aelf_i2c_host
   import aelf_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   // bus idle: scl high, sda left to its pull-up
   initial
   begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clock_i);
   endtask : tick
   // two-clock phases keep the device's minimum scl width
   task automatic clk_bit(input logic b, output logic r);
      tick(1);
      sda_oe_o = ~b;  // data moves only while scl is low
      tick(2);
      scl_o = 1'b1;
      tick(2);
      r = sda_i;
      scl_o = 1'b0;
   endtask : clk_bit
   // also serves as repeated start from scl low
   task automatic start();
      sda_oe_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
      tick(2);
      sda_oe_o = 1'b1;
      tick(2);
      scl_o = 1'b0;
   endtask : start
   task automatic stop();
      tick(1);
      sda_oe_o = 1'b1;
      tick(2);
      scl_o = 1'b1;
      tick(2);
      sda_oe_o = 1'b0;
      tick(2);
   endtask : stop
   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic mack,
                       output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
      clk_bit(mack, a);
      ack = ~a;
   endtask : xfer
   task automatic write_reg(input logic [15:0] ad, input logic [7:0] d,
                            output logic ok);
      logic [7:0] q;
      logic [3:0] a;
      start();
      xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, q, a[0]);
      xfer(ad[15:8], 1'b1, q, a[1]);
      xfer(ad[7:0], 1'b1, q, a[2]);
      xfer(d, 1'b1, q, a[3]);
      stop();
      ok = &a;
   endtask : write_reg
   // single byte read, ended by a host nack
   task automatic read_reg(input logic [15:0] ad, output logic [7:0] q);
      logic [7:0] t;
      logic       a;
      start();
      xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, t, a);
      xfer(ad[15:8], 1'b1, t, a);
      xfer(ad[7:0], 1'b1, t, a);
      start();
      xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, t, a);
      xfer(8'hff, 1'b1, q, a);
      stop();
   endtask : read_reg
endmodule : aelf_i2c_host
`default_nettype wire

// ### sim/aelf_event_latch_flag_test.sv
`timescale 1ns/1ns
`default_nettype none
//=====================================================================
// self-checking bench for the event latch and flag block
//=====================================================================
module aelf_event_latch_flag_test
   import aelf_pkg::*;
;
   logic        clock = 1'b0;
   logic        srst;
   logic        scl;
   logic        host_oe;
   logic        dut_oe;
   logic        dut_sda;
   logic        sda_w;
   logic        irq;
   logic [17:0] raw;
   int          n_fail = 0;
   int          n_tests = 0;
   int          n_irq = 0;
   logic [15:0] st_ofs [3] = '{OFS_SUPPLY_STATE, OFS_BROWN_STATE,
                               OFS_THERM_FLAGS};
   logic [15:0] clr_ofs [3] = '{OFS_SUPPLY_CLR, OFS_BROWN_CLR,
                                OFS_THERM_CLR};
   int          base [3] = '{0, 6, 10};
   // open-drain sda with pull-up
   assign sda_w = ~(host_oe | (dut_oe & ~dut_sda));
   always #5 clock = ~clock;
   // count interrupt pulses seen at the rising edge
   always @(posedge clock)
      if (irq === 1'b1) n_irq <= n_irq + 1;
   aelf_i2c_host host (
      .clock_i  (clock),
      .sda_i    (sda_w),
      .scl_o    (scl),
      .sda_oe_o (host_oe)
   );
   aelf_event_latch_flag DUT (
      .clock_i                       (clock),
      .srst_i                        (srst),
      .scl_i                         (scl),
      .sda_i                         (sda_w),
      .sda_o                         (dut_sda),
      .sda_oe_o                      (dut_oe),
      .power_on_complete_raw_i       (raw[5]),
      .power_off_complete_raw_i      (raw[4]),
      .high_rail_undervolt_raw_i     (raw[3]),
      .battery_rail_undervolt_raw_i  (raw[2]),
      .headroom_track_start_raw_i    (raw[1]),
      .headroom_track_stop_raw_i     (raw[0]),
      .brownout_level_zero_raw_i     (raw[9]),
      .brownout_level_change_raw_i   (raw[8]),
      .brownout_start_raw_i          (raw[7]),
      .brownout_stop_raw_i           (raw[6]),
      .overtemp_shutdown_start_raw_i (raw[17]),
      .overtemp_shutdown_stop_raw_i  (raw[16]),
      .heat_warning_one_start_raw_i  (raw[15]),
      .heat_warning_one_stop_raw_i   (raw[14]),
      .heat_foldback_start_raw_i     (raw[13]),
      .heat_foldback_stop_raw_i      (raw[12]),
      .load_fail_raw_i               (raw[11]),
      .speaker_overcurrent_raw_i     (raw[10]),
      .irq_o                         (irq)
   );
   //==================================================================
   // checking and bus tasks
   //==================================================================
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic ok;
      host.write_reg(a, d, ok);
      cmp8({7'h00, ok}, 8'h01);
   endtask : wr
   task automatic rd_cmp(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] q;
      host.read_reg(a, q);
      cmp8(q, exp);
   endtask : rd_cmp
   // raw level held high after the edge: a clear must stick
   task automatic ev_test(input int g, input int i);
      logic [7:0] m;
      m = 8'h01 << i;
      raw[base[g] + i] = 1'b1;
      host.tick(3);
      rd_cmp(st_ofs[g], m);
      wr(clr_ofs[g], 8'h00);
      rd_cmp(st_ofs[g], m);
      wr(clr_ofs[g], ~m);
      rd_cmp(st_ofs[g], m);
      wr(clr_ofs[g], m);
      rd_cmp(st_ofs[g], 8'h00);
      raw[base[g] + i] = 1'b0;
   endtask : ev_test
   task automatic ev_grp(input int g, input int n);
      for (int i = 0; i < n; i++) ev_test(g, i);
   endtask : ev_grp
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   //==================================================================
   // main sequence
   //==================================================================
   initial
   begin
      logic [7:0] q;
      logic       a;
      srst = 1'b1;
      raw  = '0;
      repeat (10) @(negedge clock);
      srst = 1'b0;
      rd_cmp(OFS_SUPPLY_STATE, RST_REG);
      rd_cmp(OFS_BROWN_STATE, RST_REG);
      rd_cmp(OFS_THERM_FLAGS, RST_REG);
      rd_cmp(16'h2000, 8'h00);
      host.start();
      host.xfer(8'h22, 1'b1, q, a);
      host.stop();
      cmp8({7'h00, a}, 8'h00);
      wr(OFS_SUPPLY_STATE, 8'hff);
      rd_cmp(OFS_SUPPLY_STATE, 8'h00);
      wr(OFS_IRQ_CTRL, 8'h01);
      wr(OFS_THERM_MASK, 8'hff);
      rd_cmp(OFS_THERM_MASK, 8'hff);
      rd_cmp(OFS_IRQ_CTRL, 8'h01);
      rd_cmp(OFS_SUPPLY_CLR, 8'h00);
      ev_grp(0, 6);
      ev_grp(1, 4);
      cmp8(8'(n_irq), 8'h00);
      ev_grp(2, 8);
      cmp8(8'(n_irq), 8'h08);
      // edge taken while masked shows up on unmasking
      wr(OFS_THERM_MASK, 8'h00);
      raw[17] = 1'b1;
      host.tick(3);
      rd_cmp(OFS_THERM_FLAGS, 8'h00);
      cmp8(8'(n_irq), 8'h08);
      wr(OFS_THERM_MASK, 8'h80);
      rd_cmp(OFS_THERM_FLAGS, 8'h80);
      cmp8(8'(n_irq), 8'h09);
      wr(OFS_THERM_CLR, 8'h80);
      raw[17] = 1'b0;
      // with interrupts off a new flag stays silent
      wr(OFS_IRQ_CTRL, 8'h00);
      raw[17] = 1'b1;
      host.tick(3);
      rd_cmp(OFS_THERM_FLAGS, 8'h80);
      cmp8(8'(n_irq), 8'h09);
      summarize();
   end
   // whole run is near 32k cycles; 100k cycles means a hang
   initial
   begin
      #1000000;
      n_fail++;
      summarize();
   end
endmodule : aelf_event_latch_flag_test
`default_nettype wire
